// ---- bench/dmsr_master_model.sv ----
module dmsr_master_model (
  input wire logic mclk,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxFrameEnd,
  output logic txReady,
  input wire logic txValid,
  input wire logic [7:0] txData
);
  timeunit 1ns;
  timeprecision 1ps;
  bit slowMode = 1'b0;

  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    rxFrameEnd = 1'b0;
    txReady = 1'b0;
  end

  // ----------------------------------------------------------------
  // Request and reply handling
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc16(input logic [7:0] b [$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction

  task automatic send(input logic [7:0] f [$], input bit badCrc);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, badCrc};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(negedge mclk);
      rxValid = 1'b1;
      rxData = f[i];
    end
    @(negedge mclk);
    rxValid = 1'b0;
    // The idle line shows the inverse, so a stale byte cannot pass for a fresh one.
    rxData = ~rxData;
    rxFrameEnd = 1'b1;
    @(negedge mclk);
    rxFrameEnd = 1'b0;
  endtask

  // A slow master drops ready on every other cycle to stretch each byte.
  task automatic collect(output logic [7:0] r [$], input int limit);
    r = {};
    for (int n = 0; n < limit; n++) begin
      @(negedge mclk);
      if (r.size() > 0 && txValid !== 1'b1) break;
      txReady = slowMode ? ~txReady : 1'b1;
      if (txValid === 1'b1 && txReady === 1'b1) r.push_back(txData);
    end
    txReady = 1'b0;
  endtask
endmodule

// ---- bench/drive_modbus_status_registers_tb.sv ----
module drive_modbus_status_registers_tb;
  import dmsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] CODES [24] = '{8'h10, 8'h11, 8'h12, 8'h1f, 8'h20, 8'h21, 8'h22,
    8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h32, 8'h33, 8'h34, 8'h35, 8'h28, 8'h29, 8'h2b,
    8'h2c, 8'h46, 8'h47, 8'h48, 8'h49};
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] stationAddr = 8'h01;
  logic [7:0] statusFlags = 8'ha5;
  logic [FAULT_NUM-1:0] faultEvents = '0;
  logic faultClear = 1'b0;
  logic rxValid, rxFrameEnd, txReady, txValid;
  logic [7:0] rxData, txData, faultCode, expFault;
  logic [15:0] maxFreq, fbk;
  logic [15:0] v [6:22];
  logic [7:0] rep [$];
  int n_errors = 0;
  int n_compared = 0;

  always #2 mclk = ~mclk;

  dmsr_top dut (.mclk(mclk), .arst_n(arst_n), .stationAddr(stationAddr), .rxValid(rxValid),
    .rxData(rxData), .rxFrameEnd(rxFrameEnd), .txReady(txReady), .txValid(txValid),
    .txData(txData), .statusFlags(statusFlags), .faultEvents(faultEvents),
    .faultClear(faultClear), .faultCode(faultCode), .maxFrequencySetting(maxFreq),
    .speedActual(v[7]), .outputCurrent(v[8]), .motorTorque(v[9]), .outputPower(v[10]),
    .digitalInputs(v[11]), .deviceType(v[12]), .ratedOutput(v[13]),
    .ratedInputVoltage(v[14]), .controlFwVersion(v[15]), .powerFwVersion(v[16]),
    .serialNumber(v[17]), .analogInputFirst(v[20]), .analogInputSecond(v[21]),
    .speedSetpoint(v[22]), .processFeedback(fbk));

  dmsr_master_model m (.mclk(mclk), .rxValid(rxValid), .rxData(rxData),
    .rxFrameEnd(rxFrameEnd), .txReady(txReady), .txValid(txValid), .txData(txData));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] expReg(input int n);
    case (n)
      6: return {expFault, statusFlags};
      7: return (v[7] < maxFreq) ? v[7] : maxFreq;
      18, 19: return 16'h0000;
      22: return v[22] - fbk;
      default: return v[n];
    endcase
  endfunction

  task automatic xact(input logic [7:0] a, f, input logic [15:0] s, q, input bit bad);
    m.send({a, f, s[15:8], s[7:0], q[15:8], q[7:0]}, bad);
    m.collect(rep, 80 + 8 * int'(q));
  endtask

  task automatic rd(input logic [15:0] s, q);
    logic [7:0] body [$];
    xact(8'h01, 8'h03, s, q, 1'b0);
    check("reply length", 16'(5 + 2 * q), 16'(rep.size()));
    if (rep.size() == 5 + 2 * q) begin
      check("station", 16'h0001, 16'(rep[0]));
      check("function", 16'h0003, 16'(rep[1]));
      check("byte count", 16'(2 * q), 16'(rep[2]));
      for (int i = 0; i < q; i++) begin
        check("register", expReg(s + 1 + i), {rep[3 + 2 * i], rep[4 + 2 * i]});
      end
      body = rep[0:$-2];
      check("crc", m.crc16(body), {rep[$], rep[$-1]});
    end
  endtask

  task automatic exc(input logic [7:0] f, input logic [15:0] s, q, input logic [7:0] code);
    xact(8'h01, f, s, q, 1'b0);
    check("exception length", 16'h0005, 16'(rep.size()));
    if (rep.size() == 5) begin
      check("exception code", {8'h83, code}, {rep[1], rep[2]});
    end
  endtask

  task automatic silent(input logic [7:0] a, input bit bad);
    xact(a, 8'h03, 16'h0005, 16'h0001, bad);
    check("reply bytes", 16'h0000, 16'(rep.size()));
  endtask

  task automatic pulse(input int i, input bit clr);
    @(negedge mclk);
    faultEvents[i] = 1'b1;
    faultClear = clr;
    @(negedge mclk);
    faultEvents = '0;
    faultClear = 1'b0;
  endtask

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    for (int k = 6; k <= 22; k++) v[k] = {k[7:0], ~k[7:0]};
    v[7] = 16'h0300;
    maxFreq = 16'h0200;
    v[22] = 16'h0010;
    fbk = 16'h0020;
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    pulse(0, 1'b0);
    expFault = 8'h10;
    rd(16'h0005, 16'h0001);
    // Each code is loaded in a clear cycle, then a later event must not replace it.
    for (int i = 0; i < 24; i++) begin
      pulse(i, 1'b1);
      pulse(0, 1'b0);
      check("fault code", 16'(CODES[i]), 16'(faultCode));
    end
    expFault = CODES[23];
    m.slowMode = 1'b1;
    rd(16'h0006, 16'h0010);
    m.slowMode = 1'b0;
    @(negedge mclk);
    v[7] = 16'h0100;
    rd(16'h0006, 16'h0001);
    rd(16'h0015, 16'h0001);
    rd(16'h0007, 16'h0001);
    rd(16'h0005, 16'h0001);
    exc(8'h04, 16'h0005, 16'h0001, 8'h01);
    exc(8'h03, 16'h0016, 16'h0001, 8'h02);
    exc(8'h03, 16'h0005, 16'h0000, 8'h03);
    silent(8'h02, 1'b0);
    silent(8'h00, 1'b0);
    silent(8'h01, 1'b1);
    give_verdict();
  end

  initial begin
    #100000;
    n_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    give_verdict();
  end
endmodule

// ---- design/dmsr_crc16.sv ----
module dmsr_crc16 import dmsr_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  dmsr_crc_if.engine crcPort
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic [15:0] step;

  // ----------------------------------------------------------------
  // Reflected CRC-16, one byte per cycle
  // ----------------------------------------------------------------
  always_comb begin
    step = crc_q ^ {8'h00, crcPort.data};
    for (int i = 0; i < 8; i++) begin
      step = step[0] ? ((step >> 1) ^ CRC_POLY) : (step >> 1);
    end
    crc_d = crc_q;
    if (crcPort.clear) begin
      crc_d = CRC_INIT;
    end else if (crcPort.feed) begin
      crc_d = step;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      crc_q <= CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crcPort.crc = crc_q;
  assign crcPort.crcNext = step;

  a_crc_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    crcPort.clear |=> crc_q == CRC_INIT) else $error("crc not reset by clear");

endmodule

// ---- design/dmsr_crc_if.sv ----
interface dmsr_crc_if;
  logic clear;
  logic feed;
  logic [7:0] data;
  logic [15:0] crc;
  logic [15:0] crcNext;
  modport engine(input clear, input feed, input data, output crc, output crcNext);
  modport user(output clear, output feed, output data, input crc, input crcNext);
endinterface

// ---- design/dmsr_pkg.sv ----
package dmsr_pkg;

  // ----------------------------------------------------------------
  // Frame layout and protocol codes
  // ----------------------------------------------------------------
  localparam logic [3:0] REQ_LEN = 4'h8;
  localparam logic [3:0] RX_CNT_MAX = 4'h9;
  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_QTY = 8'h03;
  localparam logic [7:0] BROADCAST = 8'h00;
  localparam logic [7:0] HDR_LEN = 8'h03;
  localparam logic [15:0] MAX_QTY = 16'h007d;
  localparam logic [15:0] WIRE_OFFSET = 16'h0001;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  // ----------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_FIRST = 16'h0006;
  localparam logic [15:0] REG_STATUS = 16'h0006;
  localparam logic [15:0] REG_SPEED = 16'h0007;
  localparam logic [15:0] REG_CURRENT = 16'h0008;
  localparam logic [15:0] REG_TORQUE = 16'h0009;
  localparam logic [15:0] REG_POWER = 16'h000a;
  localparam logic [15:0] REG_INPUTS = 16'h000b;
  localparam logic [15:0] REG_TYPE = 16'h000c;
  localparam logic [15:0] REG_RATED = 16'h000d;
  localparam logic [15:0] REG_VOLTAGE = 16'h000e;
  localparam logic [15:0] REG_CTRL_FW = 16'h000f;
  localparam logic [15:0] REG_POWER_FW = 16'h0010;
  localparam logic [15:0] REG_SERIAL = 16'h0011;
  localparam logic [15:0] REG_ANALOG1 = 16'h0014;
  localparam logic [15:0] REG_ANALOG2 = 16'h0015;
  localparam logic [15:0] REG_SPEED_ERR = 16'h0016;
  localparam logic [15:0] REG_LAST = 16'h0016;

  // ----------------------------------------------------------------
  // Fault codes, one per fault event line, lowest index wins
  // ----------------------------------------------------------------
  localparam int FAULT_NUM = 24;
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_CODES [FAULT_NUM] = '{
    8'h10, 8'h11, 8'h12,
    8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
    8'h32, 8'h33, 8'h34, 8'h35,
    8'h28, 8'h29, 8'h2b, 8'h2c,
    8'h46, 8'h47, 8'h48, 8'h49
  };

  typedef enum logic [2:0] {
    ST_RECV = 3'h1,
    ST_CHECK = 3'h2,
    ST_SEND = 3'h4
  } dmsr_state_e;

endpackage

// ---- design/dmsr_top.sv ----
module dmsr_top import dmsr_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] stationAddr,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxFrameEnd,
  input wire logic txReady,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic [7:0] statusFlags,
  input wire logic [FAULT_NUM-1:0] faultEvents,
  input wire logic faultClear,
  output logic [7:0] faultCode,
  input wire logic [15:0] maxFrequencySetting,
  input wire logic [15:0] speedActual,
  input wire logic [15:0] outputCurrent,
  input wire logic [15:0] motorTorque,
  input wire logic [15:0] outputPower,
  input wire logic [15:0] digitalInputs,
  input wire logic [15:0] deviceType,
  input wire logic [15:0] ratedOutput,
  input wire logic [15:0] ratedInputVoltage,
  input wire logic [15:0] controlFwVersion,
  input wire logic [15:0] powerFwVersion,
  input wire logic [15:0] serialNumber,
  input wire logic [15:0] analogInputFirst,
  input wire logic [15:0] analogInputSecond,
  input wire logic [15:0] speedSetpoint,
  input wire logic [15:0] processFeedback
);

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  logic [7:0] fault_q;
  logic [7:0] fault_d;

  function automatic logic [15:0] readReg(input logic [15:0] num);
    logic [15:0] val;
    val = 16'h0000;
    if (num == REG_STATUS) begin
      val = {fault_q, statusFlags};
    end else if (num == REG_SPEED) begin
      val = (speedActual > maxFrequencySetting) ? maxFrequencySetting : speedActual;
    end else if (num == REG_CURRENT) begin
      val = outputCurrent;
    end else if (num == REG_TORQUE) begin
      val = motorTorque;
    end else if (num == REG_POWER) begin
      val = outputPower;
    end else if (num == REG_INPUTS) begin
      val = digitalInputs;
    end else if (num == REG_TYPE) begin
      val = deviceType;
    end else if (num == REG_RATED) begin
      val = ratedOutput;
    end else if (num == REG_VOLTAGE) begin
      val = ratedInputVoltage;
    end else if (num == REG_CTRL_FW) begin
      val = controlFwVersion;
    end else if (num == REG_POWER_FW) begin
      val = powerFwVersion;
    end else if (num == REG_SERIAL) begin
      val = serialNumber;
    end else if (num == REG_ANALOG1) begin
      val = analogInputFirst;
    end else if (num == REG_ANALOG2) begin
      val = analogInputSecond;
    end else if (num == REG_SPEED_ERR) begin
      val = speedSetpoint - processFeedback;
    end
    return val;
  endfunction

  // ----------------------------------------------------------------
  // Fault byte
  // ----------------------------------------------------------------
  // The first fault holds until cleared, so a burst of follow-on faults
  // cannot hide the root cause. A new fault in the clearing cycle wins.
  always_comb begin
    fault_d = fault_q;
    if (faultClear) begin
      fault_d = FAULT_NONE;
    end
    if (fault_q == FAULT_NONE || faultClear) begin
      for (int i = FAULT_NUM - 1; i >= 0; i--) begin
        if (faultEvents[i]) begin
          fault_d = FAULT_CODES[i];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fault_q <= FAULT_NONE;
    end else begin
      fault_q <= fault_d;
    end
  end

  assign faultCode = fault_q;

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  dmsr_crc_if crcBus();

  dmsr_crc16 crcEngine (
    .mclk(mclk),
    .arst_n(arst_n),
    .crcPort(crcBus)
  );

  dmsr_state_e state_q;
  dmsr_state_e state_d;
  logic [3:0] rxCnt_q;
  logic [3:0] rxCnt_d;
  logic [7:0] rxBuf_q [REQ_LEN];
  logic [7:0] rxBuf_d [REQ_LEN];
  logic [7:0] txIdx_q;
  logic [7:0] txIdx_d;
  logic [7:0] txLen_q;
  logic [7:0] txLen_d;
  logic [7:0] txData_q;
  logic [7:0] txData_d;
  logic txValid_q;
  logic txValid_d;
  logic [7:0] exc_q;
  logic [7:0] exc_d;
  logic [15:0] startNum_q;
  logic [15:0] startNum_d;

  logic [15:0] startWire;
  logic [15:0] qtyReq;
  logic [16:0] lastNum;
  logic accept;
  logic [7:0] nextIdx;
  logic [7:0] dataOff;
  logic [15:0] dataReg;
  logic [7:0] nextByte;
  logic [15:0] firstWord;

  assign startWire = {rxBuf_q[2], rxBuf_q[3]};
  assign qtyReq = {rxBuf_q[4], rxBuf_q[5]};
  assign lastNum = {1'b0, startWire} + {1'b0, WIRE_OFFSET} + {1'b0, qtyReq} - 17'h00001;
  assign accept = txValid_q && txReady;
  assign nextIdx = txIdx_q + 8'h01;
  assign dataOff = nextIdx - HDR_LEN;
  // A process and not an assign, so that a change on a live input re-runs the read.
  always_comb begin
    dataReg = readReg(startNum_q + {9'h000, dataOff[7:1]});
    firstWord = readReg(startWire + WIRE_OFFSET);
  end

  // Next byte of the reply, selected by its position in the frame.
  always_comb begin
    if (nextIdx == txLen_q) begin
      nextByte = crcBus.crcNext[7:0];
    end else if (nextIdx == txLen_q + 8'h01) begin
      nextByte = crcBus.crc[15:8];
    end else if (nextIdx == 8'h01) begin
      nextByte = (exc_q != EXC_NONE) ? (FUNC_READ | EXC_FLAG) : FUNC_READ;
    end else if (nextIdx == 8'h02) begin
      nextByte = (exc_q != EXC_NONE) ? exc_q : (txLen_q - HDR_LEN);
    end else begin
      nextByte = dataOff[0] ? dataReg[7:0] : dataReg[15:8];
    end
  end

  always_comb begin
    state_d = state_q;
    rxCnt_d = rxCnt_q;
    rxBuf_d = rxBuf_q;
    txIdx_d = txIdx_q;
    txLen_d = txLen_q;
    txData_d = txData_q;
    txValid_d = txValid_q;
    exc_d = exc_q;
    startNum_d = startNum_q;
    crcBus.clear = 1'b0;
    crcBus.feed = 1'b0;
    crcBus.data = rxData;
    case (state_q)
      ST_RECV: begin
        crcBus.feed = rxValid;
        if (rxValid) begin
          if (rxCnt_q < REQ_LEN) begin
            rxBuf_d[rxCnt_q[2:0]] = rxData;
          end
          if (rxCnt_q < RX_CNT_MAX) begin
            rxCnt_d = rxCnt_q + 4'h1;
          end
        end
        if (rxFrameEnd && rxCnt_q != 4'h0) begin
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // Damaged, foreign and broadcast frames are dropped silently.
        rxCnt_d = 4'h0;
        crcBus.clear = 1'b1;
        state_d = ST_RECV;
        if (rxCnt_q == REQ_LEN && crcBus.crc == 16'h0000 &&
            rxBuf_q[0] != BROADCAST && rxBuf_q[0] == stationAddr) begin
          state_d = ST_SEND;
          txIdx_d = 8'h00;
          txData_d = stationAddr;
          txValid_d = 1'b1;
          txLen_d = HDR_LEN;
          startNum_d = startWire + WIRE_OFFSET;
          if (rxBuf_q[1] != FUNC_READ) begin
            exc_d = EXC_FUNC;
          end else if (qtyReq == 16'h0000 || qtyReq > MAX_QTY) begin
            exc_d = EXC_QTY;
          end else if (startNum_d < REG_FIRST || lastNum > {1'b0, REG_LAST}) begin
            exc_d = EXC_ADDR;
          end else begin
            exc_d = EXC_NONE;
            txLen_d = HDR_LEN + {qtyReq[6:0], 1'b0};
          end
        end
      end
      ST_SEND: begin
        crcBus.data = txData_q;
        crcBus.feed = accept && txIdx_q < txLen_q;
        if (accept) begin
          txIdx_d = nextIdx;
          txData_d = nextByte;
          if (txIdx_q == txLen_q + 8'h01) begin
            txValid_d = 1'b0;
            crcBus.clear = 1'b1;
            state_d = ST_RECV;
          end
        end
      end
      default: begin
        state_d = ST_RECV;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_RECV;
      rxCnt_q <= 4'h0;
      for (int i = 0; i < REQ_LEN; i++) begin
        rxBuf_q[i] <= 8'h00;
      end
      txIdx_q <= 8'h00;
      txLen_q <= HDR_LEN;
      txData_q <= 8'h00;
      txValid_q <= 1'b0;
      exc_q <= EXC_NONE;
      startNum_q <= REG_FIRST;
    end else begin
      state_q <= state_d;
      rxCnt_q <= rxCnt_d;
      rxBuf_q <= rxBuf_d;
      txIdx_q <= txIdx_d;
      txLen_q <= txLen_d;
      txData_q <= txData_d;
      txValid_q <= txValid_d;
      exc_q <= exc_d;
      startNum_q <= startNum_d;
    end
  end

  assign txValid = txValid_q;
  assign txData = txData_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_bcast_silent: assert property (@(posedge mclk) disable iff (!arst_n)
    state_q == ST_CHECK && rxBuf_q[0] == BROADCAST |=> state_q == ST_RECV && !txValid_q)
    else $error("broadcast was answered");

  a_foreign_silent: assert property (@(posedge mclk) disable iff (!arst_n)
    state_q == ST_CHECK && rxBuf_q[0] != stationAddr |=> !txValid_q)
    else $error("foreign station answered");

  a_first_byte: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(txValid_q) |-> txData_q == stationAddr && txIdx_q == 8'h00)
    else $error("reply does not open with station address");

  a_func_echo: assert property (@(posedge mclk) disable iff (!arst_n)
    txValid_q && txIdx_q == 8'h01 && exc_q == EXC_NONE |-> txData_q == FUNC_READ)
    else $error("function code not echoed");

  a_byte_count: assert property (@(posedge mclk) disable iff (!arst_n)
    txValid_q && txIdx_q == 8'h02 && exc_q == EXC_NONE |-> txData_q == qtyReq[6:0] * 8'h02)
    else $error("byte count is not twice register count");

  a_wire_offset: assert property (@(posedge mclk) disable iff (!arst_n)
    txValid_q && txIdx_q == HDR_LEN && exc_q == EXC_NONE
    |-> txData_q == firstWord[15:8])
    else $error("first data byte not from addressed register");

  a_tx_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    txValid_q && !txReady |=> txValid_q && $stable(txData_q))
    else $error("reply byte changed while stalled");

  a_frame_end: assert property (@(posedge mclk) disable iff (!arst_n)
    accept && txIdx_q == txLen_q + 8'h01 |=> !txValid_q ##1 state_q == ST_RECV)
    else $error("reply did not end after crc high byte");

  a_fault_latch: assert property (@(posedge mclk) disable iff (!arst_n)
    fault_q == FAULT_NONE && faultEvents[0] |=> fault_q == FAULT_CODES[0])
    else $error("thermistor fault code not reported");

  a_fault_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
    fault_q != FAULT_NONE && !faultClear |=> $stable(fault_q))
    else $error("fault byte changed without clear");

  a_speed_cap: assert property (@(posedge mclk) disable iff (!arst_n)
    txValid_q && txIdx_q == HDR_LEN && exc_q == EXC_NONE && startWire == REG_SPEED - WIRE_OFFSET
    |-> txData_q <= maxFrequencySetting[15:8])
    else $error("speed above maximum frequency");

  a_current_map: assert property (@(posedge mclk) disable iff (!arst_n)
    txValid_q && txIdx_q == HDR_LEN && exc_q == EXC_NONE && startWire == REG_CURRENT - WIRE_OFFSET
    |-> txData_q == outputCurrent[15:8])
    else $error("current register wrong");

  c_normal_read: cover property (@(posedge mclk) disable iff (!arst_n)
    state_q == ST_CHECK ##1 state_q == ST_SEND && exc_q == EXC_NONE);

  c_multi_read: cover property (@(posedge mclk) disable iff (!arst_n)
    state_q == ST_SEND && txLen_q > HDR_LEN + 8'h04);

  c_exception: cover property (@(posedge mclk) disable iff (!arst_n)
    state_q == ST_SEND && exc_q != EXC_NONE);

  c_broadcast: cover property (@(posedge mclk) disable iff (!arst_n)
    state_q == ST_CHECK && rxBuf_q[0] == BROADCAST && rxCnt_q == REQ_LEN);

  c_fault_in_clear: cover property (@(posedge mclk) disable iff (!arst_n)
    faultClear && |faultEvents);

endmodule
